/* File: rtl/sps_serial_port.sv */
// Serial host port with sync/reset pulse classifier and conversion-ready pulse generator
//
// Summary of operation
// - Low for 2048 clock periods resets device.
// - Low 1 to 2047 periods means synchronize.
// - Sample sync/reset pin on master clock rising edge.
// - Ready output stays high at least four periods.
// - Ready low pulse lasts four periods.
// - Capture serial input on falling serial clock.
// - Launch serial output after rising serial clock.
// - Drive serial output only while selected.
// - Release serial output when select rises.
`timescale 1ns/1ps
module sps_serial_port
	import sps_pkg::*;
#(
	parameter int WORD_W = sps_pkg::SPS_WORD_W,
	parameter int RESET_LOW_CYC = sps_pkg::SPS_RESET_LOW_CYC,
	parameter int SYNC_MAX_CYC = sps_pkg::SPS_SYNC_MAX_CYC,
	parameter int RDY_LOW_CYC = sps_pkg::SPS_RDY_LOW_CYC,
	parameter int RDY_HIGH_CYC = sps_pkg::SPS_RDY_HIGH_CYC,
	parameter int CONV_PERIOD = sps_pkg::SPS_CONV_PERIOD
) (
	// Master clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Sync/reset pin, active low
	input wire logic sync_reset_n,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// Conversion-ready pin, active low pulse
	output logic conversion_ready_out,
	// Device core side
	input wire logic [WORD_W-1:0] conv_data,
	output logic [WORD_W-1:0] rx_word,
	output logic rx_valid,
	output logic sync_pulse,
	output logic dev_reset
);
	import sps_pkg::*;

	localparam int LCW = $clog2(RESET_LOW_CYC + 1);
	localparam int PCW = $clog2(CONV_PERIOD);
	localparam int RCW = $clog2(RDY_LOW_CYC + RDY_HIGH_CYC + 1);
	localparam int BCW = $clog2(WORD_W + 1);
	localparam logic [LCW-1:0] RST_CNT = LCW'(RESET_LOW_CYC);
	localparam logic [LCW-1:0] SYNC_MAX = LCW'(SYNC_MAX_CYC);
	localparam logic [PCW-1:0] PER_LAST = PCW'(CONV_PERIOD - 1);
	localparam logic [RCW-1:0] LOW_LAST = RCW'(RDY_LOW_CYC - 1);
	localparam logic [RCW-1:0] HIGH_LAST = RCW'(RDY_HIGH_CYC - 1);
	localparam logic [BCW-1:0] BIT_LAST = BCW'(WORD_W - 1);

	// Master clock domain state
	logic sr_meta_r, sr_sync_r;
	logic cs_meta_r, cs_sync_r;
	logic tg_meta_r, tg_sync_r, tg_last_r;
	logic [LCW-1:0] low_cnt_r, low_cnt_nxt;
	logic [PCW-1:0] conv_cnt_r, conv_cnt_nxt;
	sps_rdy_state_t rdy_st_r, rdy_st_nxt;
	logic [RCW-1:0] rdy_cnt_r, rdy_cnt_nxt;
	logic rdy_out_r, rdy_out_nxt;
	logic [WORD_W-1:0] tx_hold_r, tx_hold_nxt;
	logic [WORD_W-1:0] rx_word_r, rx_word_nxt;
	logic rx_valid_r, rx_valid_nxt;
	logic sync_r, sync_nxt;
	logic dev_rst_r, dev_rst_nxt;
	logic sync_evt, conv_evt;

	// Link domain state
	logic [BCW-1:0] rx_cnt_r, rx_cnt_nxt;
	logic [WORD_W-1:0] rx_sh_r, rx_sh_nxt;
	logic [WORD_W-1:0] rx_hold_r, rx_hold_nxt;
	logic rx_tgl_r, rx_tgl_nxt;
	logic tx_first_r, tx_first_nxt;
	logic [WORD_W-1:0] tx_sh_r, tx_sh_nxt;

	always_comb begin
		// Low time counts master clock rising edges and saturates at the reset threshold
		low_cnt_nxt = low_cnt_r;
		if (!sr_sync_r) begin
			if (low_cnt_r != RST_CNT) begin
				low_cnt_nxt = low_cnt_r + LCW'(1);
			end
		end else begin
			low_cnt_nxt = '0;
		end
		// A release after a short low is a sync; a long low never yields one
		sync_evt = sr_sync_r && (low_cnt_r != '0) && (low_cnt_r <= SYNC_MAX);
		dev_rst_nxt = (low_cnt_nxt == RST_CNT);
		sync_nxt = sync_evt;

		// Conversion timing restarts at the end of a sync pulse
		conv_evt = 1'b0;
		if (sync_evt) begin
			conv_cnt_nxt = '0;
		end else if (conv_cnt_r == PER_LAST) begin
			conv_cnt_nxt = '0;
			conv_evt = 1'b1;
		end else begin
			conv_cnt_nxt = conv_cnt_r + PCW'(1);
		end

		// Word only refreshed between frames so the link never loads a changing value
		tx_hold_nxt = tx_hold_r;
		if (conv_evt && cs_sync_r) begin
			tx_hold_nxt = conv_data;
		end

		// Ready pulse: low phase, then a guaranteed high phase before the next one
		rdy_st_nxt = rdy_st_r;
		rdy_cnt_nxt = rdy_cnt_r;
		rdy_out_nxt = rdy_out_r;
		case (rdy_st_r)
			SPS_RDY_IDLE: begin
				rdy_out_nxt = SPS_PIN_IDLE;
				if (conv_evt) begin
					rdy_st_nxt = SPS_RDY_LOW;
					rdy_cnt_nxt = '0;
					rdy_out_nxt = 1'b0;
				end
			end
			SPS_RDY_LOW: begin
				rdy_out_nxt = 1'b0;
				rdy_cnt_nxt = rdy_cnt_r + RCW'(1);
				if (rdy_cnt_r == LOW_LAST) begin
					rdy_st_nxt = SPS_RDY_HIGH;
					rdy_cnt_nxt = '0;
					rdy_out_nxt = SPS_PIN_IDLE;
				end
			end
			SPS_RDY_HIGH: begin
				rdy_out_nxt = SPS_PIN_IDLE;
				rdy_cnt_nxt = rdy_cnt_r + RCW'(1);
				if (rdy_cnt_r == HIGH_LAST) begin
					rdy_st_nxt = SPS_RDY_IDLE;
					rdy_cnt_nxt = '0;
				end
			end
			default: begin
				rdy_st_nxt = SPS_RDY_IDLE;
				rdy_cnt_nxt = '0;
				rdy_out_nxt = SPS_PIN_IDLE;
			end
		endcase

		// Received word handed over by toggle; the link holds it for a whole word time
		rx_word_nxt = rx_word_r;
		rx_valid_nxt = 1'b0;
		if (tg_sync_r != tg_last_r) begin
			rx_word_nxt = rx_hold_r;
			rx_valid_nxt = 1'b1;
		end

		// Device reset clears timing and data but not the pin measurement itself
		if (dev_rst_r) begin
			conv_cnt_nxt = '0;
			tx_hold_nxt = '0;
			rx_word_nxt = '0;
			rx_valid_nxt = 1'b0;
			rdy_st_nxt = SPS_RDY_IDLE;
			rdy_cnt_nxt = '0;
			rdy_out_nxt = SPS_PIN_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sr_meta_r <= SPS_PIN_IDLE;
			sr_sync_r <= SPS_PIN_IDLE;
			cs_meta_r <= SPS_PIN_IDLE;
			cs_sync_r <= SPS_PIN_IDLE;
			tg_meta_r <= 1'b0;
			tg_sync_r <= 1'b0;
			tg_last_r <= 1'b0;
			low_cnt_r <= '0;
			conv_cnt_r <= '0;
			rdy_st_r <= SPS_RDY_IDLE;
			rdy_cnt_r <= '0;
			rdy_out_r <= SPS_PIN_IDLE;
			tx_hold_r <= '0;
			rx_word_r <= '0;
			rx_valid_r <= 1'b0;
			sync_r <= 1'b0;
			dev_rst_r <= 1'b0;
		end else begin
			sr_meta_r <= sync_reset_n;
			sr_sync_r <= sr_meta_r;
			cs_meta_r <= cs_n;
			cs_sync_r <= cs_meta_r;
			tg_meta_r <= rx_tgl_r;
			tg_sync_r <= tg_meta_r;
			tg_last_r <= tg_sync_r;
			low_cnt_r <= low_cnt_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			rdy_st_r <= rdy_st_nxt;
			rdy_cnt_r <= rdy_cnt_nxt;
			rdy_out_r <= rdy_out_nxt;
			tx_hold_r <= tx_hold_nxt;
			rx_word_r <= rx_word_nxt;
			rx_valid_r <= rx_valid_nxt;
			sync_r <= sync_nxt;
			dev_rst_r <= dev_rst_nxt;
		end
	end

	// Link side: the serial clock stops between frames, so select ends the frame state
	always_comb begin
		rx_sh_nxt = {rx_sh_r[WORD_W-2:0], sdi};
		rx_cnt_nxt = rx_cnt_r + BCW'(1);
		rx_hold_nxt = rx_hold_r;
		rx_tgl_nxt = rx_tgl_r;
		if (rx_cnt_r == BIT_LAST) begin
			rx_cnt_nxt = '0;
			rx_hold_nxt = rx_sh_nxt;
			rx_tgl_nxt = ~rx_tgl_r;
		end
		// First rising edge loads the word so its first bit appears after that edge
		tx_first_nxt = 1'b0;
		if (tx_first_r) begin
			tx_sh_nxt = tx_hold_r;
		end else begin
			tx_sh_nxt = {tx_sh_r[WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			rx_cnt_r <= '0;
			rx_sh_r <= '0;
		end else begin
			rx_cnt_r <= rx_cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
		end
	end

	// Toggle and hold survive between frames; only the system reset clears them
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			rx_hold_r <= '0;
			rx_tgl_r <= 1'b0;
		end else if (!cs_n) begin
			rx_hold_r <= rx_hold_nxt;
			rx_tgl_r <= rx_tgl_nxt;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_first_r <= 1'b1;
			tx_sh_r <= '0;
		end else begin
			tx_first_r <= tx_first_nxt;
			tx_sh_r <= tx_sh_nxt;
		end
	end

	assign sdo = tx_sh_r[WORD_W-1];
	assign sdo_oe = ~cs_n;
	assign conversion_ready_out = rdy_out_r;
	assign rx_word = rx_word_r;
	assign rx_valid = rx_valid_r;
	assign sync_pulse = sync_r;
	assign dev_reset = dev_rst_r;
endmodule : sps_serial_port

/* File: rtl/sps_pkg.sv */
// Constants and types shared by the serial port, sync/reset and ready-pulse logic
package sps_pkg;
	// Serial frame word width in bits
	localparam int SPS_WORD_W = 24;
	// Low time on the sync/reset pin, in master clock periods, that forces a device reset
	localparam int SPS_RESET_LOW_CYC = 2048;
	// Longest low time still treated as a synchronization request
	localparam int SPS_SYNC_MAX_CYC = 2047;
	// Ready pulse phases, in master clock periods
	localparam int SPS_RDY_LOW_CYC = 4;
	localparam int SPS_RDY_HIGH_CYC = 4;
	// Conversion period in master clock periods
	localparam int SPS_CONV_PERIOD = 2048;
	// Idle level of the active-low pins
	localparam logic SPS_PIN_IDLE = 1'b1;

	typedef enum logic [1:0] {
		SPS_RDY_IDLE = 2'b00,
		SPS_RDY_LOW = 2'b01,
		SPS_RDY_HIGH = 2'b10
	} sps_rdy_state_t;
endpackage : sps_pkg

/* File: verification/sps_serial_port_props.sv */
// Checker: sync/reset classing, ready pulse shape, output enable
`timescale 1ns/1ps
module sps_serial_port_props #(
	parameter int RESET_LOW_CYC = 32,
	parameter int SYNC_MAX_CYC = 31,
	parameter int CONV_PERIOD = 64
) (
	// Watched ports
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sync_reset_n,
	input wire logic cs_n,
	input wire logic sdo_oe,
	input wire logic conversion_ready_out,
	input wire logic rx_valid,
	input wire logic sync_pulse,
	input wire logic dev_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Low run as sampled, kept after release since classing lags the pin
	logic [15:0] low_r, low_nxt, len_r, len_nxt, run;
	always_comb begin
		low_nxt = sync_reset_n ? 16'h0 : low_r + 16'h1;
		len_nxt = (sync_reset_n && low_r != 16'h0) ? low_r : len_r;
		run = (low_r != 16'h0) ? low_r : len_r;
	end
	always_ff @(posedge clk_sys) begin
		low_r <= low_nxt;
		len_r <= len_nxt;
	end
	a_rdy_low_len: assert property ($fell(conversion_ready_out) |->
		!conversion_ready_out[*4] ##1 conversion_ready_out) else $error("ready low length");
	a_rdy_high_len: assert property ($rose(conversion_ready_out) |->
		conversion_ready_out[*4]) else $error("ready high length");
	a_oe_follows_cs: assert property (sdo_oe == !cs_n) else $error("sdo enable");
	a_sync_short_low: assert property ($rose(sync_pulse) |->
		len_r inside {[1:SYNC_MAX_CYC]}) else $error("sync on wrong length");
	a_sync_one_cycle: assert property (sync_pulse |=> !sync_pulse) else $error("sync width");
	a_reset_long_low: assert property ($rose(dev_reset) |->
		run >= RESET_LOW_CYC) else $error("reset too early");
	a_reset_holds: assert property (dev_reset && !sync_reset_n |=> dev_reset)
		else $error("reset dropped");
	a_reset_ready_idle: assert property (dev_reset[*3] |-> conversion_ready_out)
		else $error("ready pulse in reset");
	a_sync_restart: assert property ($rose(sync_pulse) |->
		##CONV_PERIOD $fell(conversion_ready_out)) else $error("ready not realigned");
	c_sync: cover property (sync_pulse);
	c_reset: cover property ($rose(dev_reset));
	c_rx: cover property (rx_valid);
endmodule : sps_serial_port_props
bind sps_serial_port sps_serial_port_props #(.RESET_LOW_CYC(RESET_LOW_CYC),
	.SYNC_MAX_CYC(SYNC_MAX_CYC), .CONV_PERIOD(CONV_PERIOD)) u_props (.clk_sys, .rst,
	.sync_reset_n, .cs_n, .sdo_oe, .conversion_ready_out, .rx_valid, .sync_pulse, .dev_reset);

/* File: verification/sps_host_model.sv */
// Host controller model: mode 1 frames, clock idle low between frames
`timescale 1ns/1ps
module sps_host_model
	import sps_pkg::*;
(
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic line;
	// A released line must not look like held data
	always @(sdo_oe, sdo) line = sdo_oe ? sdo : ~line;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	task automatic xfer(input logic [SPS_WORD_W-1:0] tx, output logic [SPS_WORD_W-1:0] rx);
		#13 cs_n = 1'b0;
		#130;
		for (int i = SPS_WORD_W - 1; i >= 0; i--) begin
			sclk = 1'b1;
			sdi = tx[i];
			#80 sclk = 1'b0;
			rx[i] = line;
			#80;
		end
		cs_n = 1'b1;
		sdi = ~sdi;
	endtask : xfer
endmodule : sps_host_model

/* File: verification/testbench.sv */
// Bench: frames both ways, ready timing, sync and reset pulse lengths
`timescale 1ns/1ps
module testbench;
	import sps_pkg::*;
	localparam int CP = 64;
	localparam int RL = 32;
	logic clk_sys, rst, sync_reset_n, sclk, cs_n, sdi, sdo, sdo_oe, rdy_n;
	logic rx_valid, sync_pulse, dev_reset, s_seen, r_seen;
	logic [SPS_WORD_W-1:0] conv_data, rx_word, rd, tx;
	logic [SPS_WORD_W-1:0] q[$];
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	int t0, n;
	// Reset pulse held past the threshold so reset stays up while the pin is still low
	int lens[5] = '{1, RL - 1, RL, RL + 8, 2};
	sps_serial_port #(.RESET_LOW_CYC(RL), .SYNC_MAX_CYC(RL - 1), .CONV_PERIOD(CP))
		u_sps_serial_port (.clk_sys, .rst, .sync_reset_n, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
		.conversion_ready_out(rdy_n), .conv_data, .rx_word, .rx_valid, .sync_pulse, .dev_reset);
	sps_host_model u_sps_host_model (.sclk, .cs_n, .sdi, .sdo, .sdo_oe);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk_w(string nm, logic [SPS_WORD_W-1:0] e, logic [SPS_WORD_W-1:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_w
	task automatic chk_n(string nm, int e, int g);
		compares++;
		if (g != e) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_n
	task automatic tick(int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask : tick
	task automatic wait_rdy();
		int k;
		for (k = 0; rdy_n !== 1'b0 && k < 300; k++)
			tick(1);
		n = cyc;
		for (k = 0; rdy_n === 1'b0 && k < 9; k++)
			tick(1);
		chk_n("ready low", SPS_RDY_LOW_CYC, k);
	endtask : wait_rdy
	task automatic stop_test();
		$display("Checks %0d, errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// Outputs are looked at on the falling edge, half a period after they settle
	always @(negedge clk_sys) begin
		cyc++;
		if (sync_pulse === 1'b1) begin
			s_seen = 1'b1;
			t0 = cyc;
		end
		if (dev_reset === 1'b1)
			r_seen = 1'b1;
		if (rx_valid === 1'b1)
			chk_w("rx word", q.pop_front(), rx_word);
		if (cyc > 5000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		rst = 1'b1;
		sync_reset_n = 1'b1;
		void'($urandom(1));
		conv_data = SPS_WORD_W'($urandom);
		lens[4] = 2 + int'($urandom % (RL - 3));
		tick(16);
		chk_w("idle", 24'h1, 24'({dev_reset, sync_pulse, rx_valid, rdy_n}));
		rst = 1'b0;
		for (int i = 0; i < 3; i++) begin
			wait_rdy();
			tx = SPS_WORD_W'($urandom);
			q.push_back(tx);
			u_sps_host_model.xfer(tx, rd);
			chk_w("read word", conv_data, rd);
			tick(1);
			chk_w("sdo enable", '0, 24'(sdo_oe));
			conv_data = SPS_WORD_W'($urandom);
		end
		foreach (lens[j]) begin
			s_seen = 1'b0;
			r_seen = 1'b0;
			sync_reset_n = 1'b0;
			tick(lens[j]);
			sync_reset_n = 1'b1;
			tick(8);
			chk_w("sync seen", 24'(lens[j] < RL), 24'(s_seen));
			chk_w("reset seen", 24'(lens[j] >= RL), 24'(r_seen));
			if (lens[j] < RL) begin
				wait_rdy();
				chk_n("sync to ready", CP - 1, n - t0);
			end else begin
				chk_w("rx cleared", '0, rx_word);
			end
		end
		stop_test();
	end
endmodule : testbench
